/* File: rtl/ccarr_core.v */
/*
 * Counter array with five capture/compare channels: shared 16-bit counter,
 * capture, software timer, toggle output, frequency output, 8/16-bit PWM
 * and the combined interrupt request.
 * Assumes a single 40 MHz clock, an asynchronous active-low reset and a
 * processor on a plain byte-wide register port that never waits.
 */
// The address map and strobed register access are this design's own decisions.
// Operation
// - One interrupt from any enabled set flag.
// - Overflow flag on 16-bit wrap.
// - Intermediate flag on bit 8..11 overflow.
// - Flags set regardless of enables.
// - Each flag gated by own enable.
// - Mode register fields bit7 to bit0.
// - Capture edge select when match/toggle/pulse clear.
// - Capture copies counter, sets channel flag.
// - Channel flag cleared only by software.
// - Software timer flags 16-bit match.
// - Low write clears, high write sets comparator.
// - Toggle mode inverts pin on match.
// - Comparator off: pin holds, PWM zero.
// - Frequency mode: low match, toggle, add step.
// - Step zero means 256 clocks.
// - Frequency mode flag on full match.
// - PWM: match high, overflow low, polarity.
// - PWM match uses low N bits; the code runs PWM only at N=8, with no output at 9 to 11 bits.
// - PWM overflow on low N rollover; the code uses the 8-bit rollover only.
// - 8-bit PWM reloads low from high.
// - Intermediate flag marks 8-bit edge; match flags.
// - 16-bit PWM uses full compare, main overflow.
// - Timebase: div12, div4, undivided clock.
// - Low-byte read latches high byte.
`include "ccarr_regs.vh"

module ccarr_core (
    input  wire        clk,
    input  wire        nrst,
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    input  wire [4:0]  channel_pin_in,
    output wire [4:0]  channel_pin_out,
    output wire [4:0]  channel_pin_oe_n,
    output wire        irq
);

    reg  [15:0] counter;
    reg         run;
    reg         counter_overflow_flag;
    reg         intermediate_overflow_flag;
    reg  [4:0]  channel_event_flag;
    reg         overflow_irq_enable;
    reg         intermediate_irq_enable;
    reg  [2:0]  timebase_select;
    reg  [1:0]  cycle_length_select;
    reg  [4:0]  output_polarity_register;
    reg  [7:0]  counter_high_hold;
    reg  [3:0]  prescale;
    reg  [7:0]  channel_mode_n   [0:4];
    reg  [7:0]  compare_low_byte [0:4];
    reg  [7:0]  compare_high_byte[0:4];
    reg  [4:0]  pin_state;
    reg  [4:0]  pin_meta;
    reg  [4:0]  pin_sync;
    reg  [4:0]  pin_prev;
    reg         tick;
    reg  [15:0] next_counter;
    reg  [4:0]  ch_event;
    reg  [4:0]  ch_toggle;
    reg  [4:0]  ch_set_high;
    reg  [4:0]  ch_set_low;
    reg  [4:0]  ch_capture;
    reg  [4:0]  ch_step;
    reg  [4:0]  ch_reload;
    reg         wrap16;
    reg         wrap_mid;
    reg         wrap8;
    integer     i;
    integer     j;

    // Address decode helpers shared by the write and read paths.
    function is_chan;
        input [7:0] addr;
        input [7:0] base;
        begin
            is_chan = (addr >= base) && (addr < base + 8'd5);
        end
    endfunction

    function [2:0] chan_of;
        input [7:0] addr;
        input [7:0] base;
        reg   [7:0] diff;
        begin
            diff    = addr - base;
            chan_of = diff[2:0];
        end
    endfunction

    // Timebase tick: the prescaler free-runs so a code change takes effect at once.
    always @* begin
        case (timebase_select)
            `CCARR_TB_DIV12: tick = run && (prescale == `CCARR_DIV12_LAST);
            `CCARR_TB_DIV4:  tick = run && ({2'b00, prescale[1:0]} == `CCARR_DIV4_LAST);
            `CCARR_TB_SYS:   tick = run;
            default:         tick = 1'b0; // Other sources are not wired to this block.
        endcase
    end

    // Counter next value and rollover edges at each resolution.
    always @* begin
        next_counter = counter + 16'h0001;
        wrap16       = tick && (counter == 16'hffff);
        wrap8        = tick && (counter[7:0] == 8'hff);
        case (cycle_length_select)
            2'h0:    wrap_mid = wrap8;
            2'h1:    wrap_mid = tick && (counter[8:0] == 9'h1ff);
            2'h2:    wrap_mid = tick && (counter[9:0] == 10'h3ff);
            default: wrap_mid = tick && (counter[10:0] == 11'h7ff);
        endcase
    end

    // Per-channel mode decode. Events other than the PWM match act on the counter value about to be left,
    // so every channel sees the same count in the same cycle.
    always @* begin
        ch_event    = 5'h00;
        ch_toggle   = 5'h00;
        ch_set_high = 5'h00;
        ch_set_low  = 5'h00;
        ch_capture  = 5'h00;
        ch_step     = 5'h00;
        ch_reload   = 5'h00;
        for (i = 0; i < 5; i = i + 1) begin
            if (channel_mode_n[i][3:1] == 3'b000) begin
                // Capture on the selected synchronised edge.
                if ((channel_mode_n[i][`CCARR_CM_RISE] && pin_sync[i] && !pin_prev[i]) ||
                    (channel_mode_n[i][`CCARR_CM_FALL] && !pin_sync[i] && pin_prev[i])) begin
                    ch_capture[i] = 1'b1;
                    ch_event[i]   = 1'b1;
                end
            end else if (!channel_mode_n[i][`CCARR_CM_CMPEN]) begin
                // Comparator off: PWM output forced low, toggles hold.
                if (channel_mode_n[i][`CCARR_CM_PULSE] && !channel_mode_n[i][`CCARR_CM_TOGGLE])
                    ch_set_low[i] = 1'b1;
            end else if (channel_mode_n[i][`CCARR_CM_PULSE] && channel_mode_n[i][`CCARR_CM_TOGGLE]) begin
                // Frequency output on low-byte match.
                if (tick && counter[7:0] == compare_low_byte[i]) begin
                    ch_toggle[i] = 1'b1;
                    ch_step[i]   = 1'b1;
                end
                if (tick && channel_mode_n[i][`CCARR_CM_MATCH] &&
                    counter == {compare_high_byte[i], compare_low_byte[i]})
                    ch_event[i] = 1'b1;
            end else if (channel_mode_n[i][`CCARR_CM_PULSE]) begin
                if (channel_mode_n[i][`CCARR_CM_WIDE]) begin
                    // 16-bit PWM; the match is taken on the count being entered, so the high
                    // time is the period minus the compare value.
                    if (tick && next_counter == {compare_high_byte[i], compare_low_byte[i]})
                        ch_set_high[i] = 1'b1;
                    if (wrap16)
                        ch_set_low[i] = 1'b1;
                end else if (cycle_length_select == 2'h0) begin
                    // 8-bit PWM on the low byte, reloaded at overflow.
                    if (tick && next_counter[7:0] == compare_low_byte[i])
                        ch_set_high[i] = 1'b1;
                    if (wrap8) begin
                        ch_set_low[i] = 1'b1;
                        ch_reload[i]  = 1'b1;
                    end
                end
                ch_event[i] = ch_set_high[i] && channel_mode_n[i][`CCARR_CM_MATCH];
            end else if (channel_mode_n[i][`CCARR_CM_MATCH]) begin
                // Software timer, or toggle output when toggle is set.
                if (tick && counter == {compare_high_byte[i], compare_low_byte[i]}) begin
                    ch_event[i]  = 1'b1;
                    ch_toggle[i] = channel_mode_n[i][`CCARR_CM_TOGGLE];
                end
            end
        end
    end

    // Pin synchroniser: the second and third stages feed the edge detector.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_meta <= 5'h00;
            pin_sync <= 5'h00;
            pin_prev <= 5'h00;
        end else begin
            pin_meta <= channel_pin_in;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // Counter, prescaler, flags and all software-visible state.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            counter                    <= `CCARR_RST_WORD;
            prescale                   <= 4'h0;
            run                        <= 1'b0;
            counter_overflow_flag      <= 1'b0;
            intermediate_overflow_flag <= 1'b0;
            channel_event_flag         <= 5'h00;
            overflow_irq_enable        <= 1'b0;
            intermediate_irq_enable    <= 1'b0;
            timebase_select            <= `CCARR_TB_DIV12;
            cycle_length_select        <= 2'h0;
            output_polarity_register   <= 5'h00;
            counter_high_hold          <= `CCARR_RST_BYTE;
            pin_state                  <= 5'h00;
            for (j = 0; j < 5; j = j + 1) begin
                channel_mode_n[j]    <= `CCARR_RST_BYTE;
                compare_low_byte[j]  <= `CCARR_RST_BYTE;
                compare_high_byte[j] <= `CCARR_RST_BYTE;
            end
        end else begin
            prescale <= (prescale == `CCARR_DIV12_LAST) ? 4'h0 : prescale + 4'h1;
            // Software writes first; hardware sets below win over a clear.
            if (reg_wr) begin
                case (reg_addr)
                    `CCARR_ADDR_CTRL: begin
                        counter_overflow_flag <= reg_wdata[`CCARR_CTRL_OVF];
                        run                   <= reg_wdata[`CCARR_CTRL_RUN];
                        channel_event_flag    <= reg_wdata[4:0];
                    end
                    `CCARR_ADDR_MODE: begin
                        timebase_select     <= reg_wdata[`CCARR_MODE_TB_HI:`CCARR_MODE_TB_LO];
                        overflow_irq_enable <= reg_wdata[`CCARR_MODE_OVF_IE];
                    end
                    `CCARR_ADDR_PWMCFG: begin
                        intermediate_irq_enable    <= reg_wdata[`CCARR_PWM_IOVF_IE];
                        intermediate_overflow_flag <= reg_wdata[`CCARR_PWM_IOVF];
                        cycle_length_select        <= reg_wdata[`CCARR_PWM_CLS_HI:`CCARR_PWM_CLS_LO];
                    end
                    `CCARR_ADDR_POL:    output_polarity_register <= reg_wdata[4:0];
                    default: begin
                        if (is_chan(reg_addr, `CCARR_ADDR_CHMODE0))
                            channel_mode_n[chan_of(reg_addr, `CCARR_ADDR_CHMODE0)] <= reg_wdata;
                        if (is_chan(reg_addr, `CCARR_ADDR_CMPLO0)) begin
                            compare_low_byte[chan_of(reg_addr, `CCARR_ADDR_CMPLO0)] <= reg_wdata;
                            channel_mode_n[chan_of(reg_addr, `CCARR_ADDR_CMPLO0)][`CCARR_CM_CMPEN] <= 1'b0;
                        end
                        if (is_chan(reg_addr, `CCARR_ADDR_CMPHI0)) begin
                            compare_high_byte[chan_of(reg_addr, `CCARR_ADDR_CMPHI0)] <= reg_wdata;
                            channel_mode_n[chan_of(reg_addr, `CCARR_ADDR_CMPHI0)][`CCARR_CM_CMPEN] <= 1'b1;
                        end
                    end
                endcase
            end
            // Low-byte read snapshots the high byte for a coherent 16-bit read.
            if (reg_rd && reg_addr == `CCARR_ADDR_CNT_LO)
                counter_high_hold <= counter[15:8];
            if (tick)
                counter <= next_counter;
            if (wrap16)
                counter_overflow_flag <= 1'b1;
            if (wrap_mid)
                intermediate_overflow_flag <= 1'b1;
            for (j = 0; j < 5; j = j + 1) begin
                if (ch_event[j])
                    channel_event_flag[j] <= 1'b1;
                if (ch_capture[j]) begin
                    compare_low_byte[j]  <= counter[7:0];
                    compare_high_byte[j] <= counter[15:8];
                end
                // A zero step leaves the compare byte unchanged, i.e. a 256-clock half period.
                if (ch_step[j])
                    compare_low_byte[j] <= compare_low_byte[j] + compare_high_byte[j];
                if (ch_reload[j])
                    compare_low_byte[j] <= compare_high_byte[j];
                // Match edge wins if it lands on the overflow edge (compare value zero).
                if (ch_toggle[j])
                    pin_state[j] <= ~pin_state[j];
                else if (ch_set_high[j])
                    pin_state[j] <= 1'b1;
                else if (ch_set_low[j])
                    pin_state[j] <= 1'b0;
            end
        end
    end

    // Read data stands in the cycle after the read strobe only.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= `CCARR_RST_BYTE;
        end else if (!reg_rd) begin
            reg_rdata <= `CCARR_RST_BYTE;
        end else begin
            case (reg_addr)
                `CCARR_ADDR_CTRL:   reg_rdata <= {counter_overflow_flag, run, 1'b0, channel_event_flag};
                `CCARR_ADDR_MODE:   reg_rdata <= {4'h0, timebase_select, overflow_irq_enable};
                `CCARR_ADDR_CNT_LO: reg_rdata <= counter[7:0];
                `CCARR_ADDR_CNT_HI: reg_rdata <= counter_high_hold;
                `CCARR_ADDR_PWMCFG: reg_rdata <= {intermediate_irq_enable, 1'b0, intermediate_overflow_flag,
                                                  3'h0, cycle_length_select};
                `CCARR_ADDR_POL:    reg_rdata <= {3'h0, output_polarity_register};
                default: begin
                    if (is_chan(reg_addr, `CCARR_ADDR_CHMODE0))
                        reg_rdata <= channel_mode_n[chan_of(reg_addr, `CCARR_ADDR_CHMODE0)];
                    else if (is_chan(reg_addr, `CCARR_ADDR_CMPLO0))
                        reg_rdata <= compare_low_byte[chan_of(reg_addr, `CCARR_ADDR_CMPLO0)];
                    else if (is_chan(reg_addr, `CCARR_ADDR_CMPHI0))
                        reg_rdata <= compare_high_byte[chan_of(reg_addr, `CCARR_ADDR_CMPHI0)];
                    else
                        reg_rdata <= `CCARR_RST_BYTE;
                end
            endcase
        end
    end

    // Output pins: polarity applies to PWM channels only; capture channels do not drive.
    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : gen_pin
            wire pwm_mode = channel_mode_n[g][`CCARR_CM_PULSE] && !channel_mode_n[g][`CCARR_CM_TOGGLE];
            wire drives   = channel_mode_n[g][`CCARR_CM_TOGGLE] || channel_mode_n[g][`CCARR_CM_PULSE];
            assign channel_pin_out[g]  = pin_state[g] ^ (pwm_mode & output_polarity_register[g]);
            assign channel_pin_oe_n[g] = ~drives;
        end
    endgenerate

    // Combined request from each flag and its own enable.
    wire [4:0] ch_ie;
    generate
        for (g = 0; g < 5; g = g + 1) begin : gen_ie
            assign ch_ie[g] = channel_mode_n[g][`CCARR_CM_IE];
        end
    endgenerate
    assign irq = (counter_overflow_flag & overflow_irq_enable) |
                 (intermediate_overflow_flag & intermediate_irq_enable) |
                 (|(channel_event_flag & ch_ie));

endmodule

/* File: rtl/ccarr_regs.vh */
/*
 * Register offsets, field positions, reset values and timing counts for the
 * counter array capture/compare block.
 * Assumes inclusion by the block's single design file only.
 */
`ifndef CCARR_REGS_VH
`define CCARR_REGS_VH

`define CCARR_NCH            5
// Register byte offsets on the plain register port.
`define CCARR_ADDR_CTRL      8'h00
`define CCARR_ADDR_MODE      8'h01
`define CCARR_ADDR_CNT_LO    8'h02
`define CCARR_ADDR_CNT_HI    8'h03
`define CCARR_ADDR_PWMCFG    8'h04
`define CCARR_ADDR_POL       8'h05
`define CCARR_ADDR_CHMODE0   8'h10
`define CCARR_ADDR_CMPLO0    8'h18
`define CCARR_ADDR_CMPHI0    8'h20
// Control register fields.
`define CCARR_CTRL_OVF       7
`define CCARR_CTRL_RUN       6
// Array mode register fields.
`define CCARR_MODE_TB_HI     3
`define CCARR_MODE_TB_LO     1
`define CCARR_MODE_OVF_IE    0
// Pulse configuration register fields.
`define CCARR_PWM_IOVF_IE    7
`define CCARR_PWM_IOVF       5
`define CCARR_PWM_CLS_HI     1
`define CCARR_PWM_CLS_LO     0
// Channel mode register fields.
`define CCARR_CM_WIDE        7
`define CCARR_CM_CMPEN       6
`define CCARR_CM_RISE        5
`define CCARR_CM_FALL        4
`define CCARR_CM_MATCH       3
`define CCARR_CM_TOGGLE      2
`define CCARR_CM_PULSE       1
`define CCARR_CM_IE          0
// Reset values.
`define CCARR_RST_BYTE       8'h00
`define CCARR_RST_WORD       16'h0000
// Timebase codes and prescale counts.
`define CCARR_TB_DIV12       3'h0
`define CCARR_TB_DIV4        3'h1
`define CCARR_TB_SYS         3'h4
`define CCARR_DIV12_LAST     4'hb
`define CCARR_DIV4_LAST      4'h3

`endif

/* File: dv/ccarr_props.sv */
/*
 * Port checker for the counter array block.
 * Assumes it is bound to ccarr_core and sees one clock and its reset.
 */
module ccarr_props (
    input wire       clk,
    input wire       nrst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire [4:0] channel_pin_in,
    input wire [4:0] channel_pin_out,
    input wire [4:0] channel_pin_oe_n,
    input wire       irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cm [5];
    logic [4:0] tgl, pls, cen, ie, pol;
    logic [2:0] tbs;
    logic       run, oie, iie;

    // Shadow of what software wrote, so that outputs can be tied to their cause.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 5; i++) cm[i] <= 8'h00;
            {run, oie, iie, tbs, pol} <= 11'h000;
        end else if (reg_wr) begin
            for (int i = 0; i < 5; i++) begin
                if (reg_addr == 8'h10 + 8'(i)) cm[i] <= reg_wdata;
                if (reg_addr == 8'h18 + 8'(i)) cm[i][6] <= 1'b0;
                if (reg_addr == 8'h20 + 8'(i)) cm[i][6] <= 1'b1;
            end
            if (reg_addr == 8'h00) run <= reg_wdata[6];
            if (reg_addr == 8'h01) {tbs, oie} <= reg_wdata[3:0];
            if (reg_addr == 8'h04) iie <= reg_wdata[7];
            if (reg_addr == 8'h05) pol <= reg_wdata[4:0];
        end
    end

    // Mode bits pulled out of the shadow, one vector per field.
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            tgl[i] = cm[i][2];
            pls[i] = cm[i][1];
            cen[i] = cm[i][6];
            ie[i] = cm[i][0];
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence lo_rd;
        reg_rd && reg_addr == 8'h02 && run && tbs == 3'h4;
    endsequence
    sequence hi_rd;
        reg_rd && reg_addr == 8'h03;
    endsequence
    sequence pwm_off;
        pls[0] && !tgl[0] && !cen[0];
    endsequence

    oe_follows_mode_a: assert property (channel_pin_oe_n == ~(tgl | pls))
        else $error("pin enable does not follow channel mode");
    irq_gate_a: assert property (!(oie || iie || |ie) |-> !irq)
        else $error("interrupt raised with every enable off");
    flag_keep_a: assert property ($fell(irq) |-> $past(reg_wr))
        else $error("interrupt dropped without a register write");
    count_step_a: assert property (lo_rd ##1 lo_rd |=> reg_rdata == $past(reg_rdata) + 8'h01)
        else $error("undivided counter did not step by one");
    held_high_a: assert property (hi_rd ##1 hi_rd |=> $stable(reg_rdata))
        else $error("held high byte changed between reads");
    toggle_hold_a: assert property (tgl[0] && !pls[0] && !cen[0] && !reg_wr |=> $stable(channel_pin_out[0]))
        else $error("toggle pin moved with comparator off");
    pwm_zero_a: assert property (pwm_off [*3] |-> channel_pin_out[0] == pol[0])
        else $error("pulse output not at zero duty with comparator off");
    toggle_once_a: assert property ($changed(channel_pin_out[1]) && tgl[1] && !pls[1] |=>
        $stable(channel_pin_out[1]) [*8])
        else $error("toggle pin changed twice in quick succession");
endmodule

/* File: dv/ccarr_pin_model.sv */
/*
 * Model of the outside world on the five channel pins.
 * Assumes the bench asks for levels and the block's enables are active low.
 */
module ccarr_pin_model (
    input  wire       clk,
    input  wire [4:0] want,
    input  wire [4:0] pin_out,
    input  wire [4:0] pin_oe_n,
    output wire [4:0] pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] drive = 5'h00;
    logic [1:0] age [5] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h2};

    // A requested level waits until the present one has stood two clocks.
    always @(posedge clk) begin
        for (int i = 0; i < 5; i++) begin
            if (age[i] < 2'h2) age[i] <= age[i] + 2'h1;
            else if (want[i] != drive[i]) begin
                drive[i] <= want[i];
                age[i] <= 2'h1;
            end
        end
    end

    // The wire follows the block where it drives and the outside elsewhere.
    assign pin_level = (pin_oe_n & drive) | (~pin_oe_n & pin_out);
endmodule

/* File: dv/ccarr_core_tb.sv */
/*
 * Self-checking bench for the counter array block.
 * Assumes the pin model and the checker are compiled before this file.
 */
module ccarr_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [4:0]  want = 5'h00;
    wire  [7:0]  reg_rdata;
    wire  [4:0]  pin_level, channel_pin_out, channel_pin_oe_n;
    wire         irq;
    int          n_fail = 0;
    int          comparisons = 0;
    int          n;
    logic [7:0]  c, d, e;
    logic [15:0] cnt;
    logic [7:0]  code [4] = '{8'h00, 8'h02, 8'h04, 8'h08};
    logic [7:0]  diff [4] = '{8'h04, 8'h0c, 8'h00, 8'h30};
    logic [7:0]  cap [3] = '{8'h21, 8'h11, 8'h31};

    // Half period of 12.5 ns gives the 40 MHz clock.
    always #12.5 clk = ~clk;

    ccarr_core DUT (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .channel_pin_in(pin_level), .channel_pin_out(channel_pin_out),
        .channel_pin_oe_n(channel_pin_oe_n), .irq(irq));
    ccarr_pin_model pins (.clk(clk), .want(want), .pin_out(channel_pin_out), .pin_oe_n(channel_pin_oe_n),
        .pin_level(pin_level));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask
    // Bus tasks start at a clock edge and leave one idle cycle behind them.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        v = reg_rdata;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] x);
        rd(a, d);
        chk(d, x);
    endtask
    // Two reads with no gap, as the held-byte and step checks need.
    task automatic rd2(input logic [7:0] a, output logic [7:0] v1, output logic [7:0] v2);
        reg_rd <= 1'b1;
        reg_addr <= a;
        repeat (2) @(posedge clk);
        v1 = reg_rdata;
        reg_rd <= 1'b0;
        @(posedge clk);
        v2 = reg_rdata;
    endtask
    // Clocks until the pin next changes, bounded so a dead pin cannot hang the run.
    task automatic gap(input int ch, output int k);
        logic v;
        v = channel_pin_out[ch];
        k = 0;
        while (channel_pin_out[ch] === v && k < 1000) begin
            @(posedge clk);
            k++;
        end
    endtask
    task automatic high_time(output int k);
        k = 0;
        repeat (512) begin
            @(posedge clk);
            k += channel_pin_out[0];
        end
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // The longest scenario waits out one full counter wrap.
    initial begin
        #2500us;
        n_fail++;
        print_verdict();
    end

    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        wr(8'h30, 8'ha5);
        rdc(8'h30, 8'h00);
        rdc(8'h00, 8'h00);
        for (c = 0; c < 5; c++) begin
            rdc(8'h10 + c, 8'h00);
            wr(8'h10 + c, 8'h4c);
            chk(channel_pin_oe_n[c], 1'b0);
            wr(8'h18 + c, 8'h12);
            rdc(8'h10 + c, 8'h0c);
            wr(8'h20 + c, 8'h34);
            rdc(8'h10 + c, 8'h4c);
            rdc(8'h18 + c, 8'h12);
            wr(8'h10 + c, 8'h00);
        end
        // The three wired timebase codes and one unwired code over one 48-clock window, the undivided one last.
        wr(8'h00, 8'h40);
        for (int i = 0; i < 4; i++) begin
            wr(8'h01, code[i]);
            rd(8'h02, d);
            repeat (46) @(posedge clk);
            rd(8'h02, e);
            chk(8'(e - d), diff[i]);
        end
        rd2(8'h02, d, e);
        chk(e, 8'(d + 8'h01));
        rd2(8'h03, d, e);
        chk(e, d);
        // High-speed toggle on channel 1, aimed 200 counts ahead.
        rd(8'h02, cnt[7:0]);
        rd(8'h03, cnt[15:8]);
        cnt = cnt + 16'h00c8;
        wr(8'h11, 8'h4c);
        wr(8'h19, cnt[7:0]);
        wr(8'h21, cnt[15:8]);
        gap(1, n);
        chk(channel_pin_out[1], 1'b1);
        rdc(8'h00, 8'h42);
        chk(irq, 1'b0);
        wr(8'h11, 8'h4d);
        chk(irq, 1'b1);
        repeat (20) @(posedge clk);
        chk(irq, 1'b1);
        wr(8'h00, 8'h40);
        chk(irq, 1'b0);
        // Frequency output on channel 2: step 3, then a zero step.
        wr(8'h12, 8'h46);
        wr(8'h1a, 8'h00);
        wr(8'h22, 8'h03);
        gap(2, n);
        gap(2, n);
        chk(n[15:0], 16'h0003);
        wr(8'h22, 8'h00);
        gap(2, n);
        gap(2, n);
        chk(n[15:0], 16'h0100);
        // Eight-bit pulse output on channel 0, measured over two whole periods.
        wr(8'h10, 8'h42);
        wr(8'h18, 8'h40);
        wr(8'h20, 8'h40);
        repeat (300) @(posedge clk);
        high_time(n);
        chk(n[15:0], 16'h0180);
        wr(8'h05, 8'h01);
        high_time(n);
        chk(n[15:0], 16'h0080);
        wr(8'h20, 8'hc0);
        repeat (300) @(posedge clk);
        high_time(n);
        chk(n[15:0], 16'h0180);
        rdc(8'h04, 8'h20);
        wr(8'h10, 8'h02);
        repeat (4) @(posedge clk);
        high_time(n);
        chk(n[15:0], 16'h0200);
        wr(8'h05, 8'h00);
        high_time(n);
        chk(n[15:0], 16'h0000);
        // Capture on channel 4 with the counter stopped, every edge choice.
        wr(8'h00, 8'h00);
        rd(8'h02, cnt[7:0]);
        rd(8'h03, cnt[15:8]);
        for (int i = 0; i < 3; i++) begin
            wr(8'h14, cap[i]);
            want <= 5'h10;
            repeat (8) @(posedge clk);
            rd(8'h00, d);
            chk(d[4], cap[i][5]);
            chk(irq, cap[i][5]);
            wr(8'h00, 8'h00);
            want <= 5'h00;
            repeat (8) @(posedge clk);
            rd(8'h00, d);
            chk(d[4], cap[i][4]);
            wr(8'h00, 8'h00);
        end
        rd(8'h1c, d);
        rd(8'h24, e);
        chk({e, d}, cnt);
        // Full wrap at the undivided rate with its interrupt enabled.
        wr(8'h00, 8'h40);
        wr(8'h01, 8'h09);
        wr(8'h13, 8'h8b);
        wr(8'h1b, 8'h00);
        wr(8'h23, 8'h80);
        d = 8'h00;
        for (int i = 0; i < 70 && !d[7]; i++) begin
            repeat (1000) @(posedge clk);
            rd(8'h00, d);
        end
        chk(d[7], 1'b1);
        chk(d[3], 1'b1);
        chk(channel_pin_out[3], 1'b0);
        chk(irq, 1'b1);
        print_verdict();
    end
endmodule

bind ccarr_core ccarr_props u_props (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .channel_pin_in(channel_pin_in),
    .channel_pin_out(channel_pin_out), .channel_pin_oe_n(channel_pin_oe_n), .irq(irq));
